/* File: hdl/eq_strobe_control_regs.sv */
// Per-port equaliser and strobe register bank with indirect access path.
// Assumes a serial configuration slave drives byte reads and writes
// as one-cycle strobes; adaption engines sit outside this block.
//
// Overview of operation
// R1: Bypass bit selects manual equaliser, resets adaptive
// R2: Upper nibble caps adaption, resets to all ones
// R3: Software keeps ceiling above floor with floor start
// R4: Floor start uses low nibble, resets to two
// R5: Floor start control resets enabled, else start zero
// R6: Clock delay status at 0xD6, upper bits zero
// R7: Data delay status at 0xD7, upper bits zero
// R8: Port select picks which port's registers appear
// R9: Indirect control, offset, data at consecutive offsets
// R10: Host writes control, offset, then data
// R11: Host selects block, offset, then reads data
// R12: Auto-increment advances offset after each data access
// R13: Host selects 0x04 port zero, 0x08 port one
// R14: Manual strobe register at indirect offset 0x08
// R15: Coarse bits low add six buffers, high none
// R16: Fine fields add value buffers, reset zero
// R17: Software disables other adaption before manual strobe
// R18: Clock delay samples later, data delay earlier
// R19: Control layout: block 7:2, auto-increment bit 0
`timescale 1ns/1ps
`default_nettype none
module eq_strobe_control_regs
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register access from the serial slave
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rd_valid,
  // Strobe delays currently applied, per port
  input wire logic [eq_strobe_pkg::NUM_PORTS-1:0][2:0] i_applied_clock_delay,
  input wire logic [eq_strobe_pkg::NUM_PORTS-1:0][2:0] i_applied_data_delay,
  // Equaliser controls, per port
  output logic [eq_strobe_pkg::NUM_PORTS-1:0] o_eq_adapt_enable,
  output logic [eq_strobe_pkg::NUM_PORTS-1:0][5:0] o_eq_manual_value,
  output logic [eq_strobe_pkg::NUM_PORTS-1:0][3:0] o_eq_adapt_ceiling,
  output logic [eq_strobe_pkg::NUM_PORTS-1:0][3:0] o_eq_start_level,
  // Manual strobe delays, per port
  output logic [eq_strobe_pkg::NUM_PORTS-1:0][3:0] o_clock_delay_taps,
  output logic [eq_strobe_pkg::NUM_PORTS-1:0][3:0] o_data_delay_taps,
  output logic [eq_strobe_pkg::NUM_PORTS-1:0][4:0] o_sample_offset
);

  // Register map, byte addresses in the main space
  // 0x4C port select
  //   7:1  read as zero
  //   0    port shown by every per-port register below
  // 0xB0 indirect control
  //   7:2  block select: 1 is port zero strobe, 2 is port one
  //   1    reserved: writes dropped, reads zero
  //   0    auto-increment of the offset after data accesses
  // 0xB1 indirect offset
  //   7:0  offset inside the selected block, wraps at the top
  // 0xB2 indirect data
  //   7:0  byte at the selected block and offset
  // 0xD2 equaliser control, per port
  //   7:3  read as zero
  //   2    start adaption from the floor level, resets to one
  //   1:0  read as zero
  // 0xD4 equaliser bypass, per port, resets to 0x60
  //   7:5  manual stage one value
  //   4    lock mode, stored and read back only; no output carries it
  //   3:1  manual stage two value
  //   0    1 uses the manual value, 0 runs adaption
  // 0xD5 adaption limits, per port, resets to 0xF2
  //   7:4  highest setting adaption may reach
  //   3:0  start level while floor start is on
  // 0xD6 clock delay status, per port, read only
  //   7:3  read as zero
  //   2:0  clock delay now applied to the strobe circuit
  // 0xD7 data delay status, per port, read only
  //   7:3  read as zero
  //   2:0  data delay now applied to the strobe circuit
  // Strobe block offset 0x08: manual strobe byte, resets to zero
  //   7    coarse data delay: 0 adds six buffers, 1 none
  //   6:4  fine data delay: adds its value in buffers
  //   3    coarse clock delay: 0 adds six buffers, 1 none
  //   2:0  fine clock delay: adds its value in buffers
  // Other blocks and offsets read zero and drop their writes
  // Writes to the read-only and unmapped addresses are ignored

  eq_strobe_pkg::bank_state_type state_reg;
  eq_strobe_pkg::bank_state_type state_next;

  // Maps a block select to a strobe port; bit PORT_W flags a hit.
  // Only block selects 1 and 2 hold anything here; any other block
  // reads zero through the data register and drops its writes.
  function automatic logic [eq_strobe_pkg::PORT_W:0] strobe_block(
    input logic [7:0] ctl);
    logic [7:0] blk;
    blk = {2'b00, ctl[eq_strobe_pkg::IND_BLOCK_HI:eq_strobe_pkg::IND_BLOCK_LO]};
    if ({blk[5:0], 2'b00} == eq_strobe_pkg::BLOCK_STROBE_PORT0) // [R13]
      strobe_block = {1'b1, 1'b0};
    else if ({blk[5:0], 2'b00} == eq_strobe_pkg::BLOCK_STROBE_PORT1) // [R13]
      strobe_block = {1'b1, 1'b1};
    else
      strobe_block = '0;
  endfunction

  logic [eq_strobe_pkg::PORT_W:0] ind_hit;
  logic ind_strobe_sel;
  logic [eq_strobe_pkg::PORT_W-1:0] ind_port;
  logic [eq_strobe_pkg::PORT_W-1:0] port;
  logic data_access;
  logic auto_inc;

  // Indirect target decode
  always_comb
  begin
    ind_hit = strobe_block(state_reg.ind_control); // [R19]
    ind_port = ind_hit[eq_strobe_pkg::PORT_W-1:0];
    ind_strobe_sel = ind_hit[eq_strobe_pkg::PORT_W] &&
      (state_reg.ind_offset == eq_strobe_pkg::OFS_MANUAL_STROBE_DELAY); // [R14]
    port = state_reg.port_sel; // [R8]
    // Every data access counts, hit or miss, so a host can step
    // over offsets that hold nothing
    data_access = (i_reg_wr || i_reg_rd) &&
      (i_reg_addr == eq_strobe_pkg::ADDR_INDIRECT_DATA); // [R12]
    auto_inc = state_reg.ind_control[eq_strobe_pkg::IND_AUTO_INC_BIT];
  end

  // Next state: register writes, indirect path and read data
  always_comb
  begin
    state_next = state_reg;
    state_next.rd_valid = 1'b0;
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        eq_strobe_pkg::ADDR_PORT_SELECT:
          state_next.port_sel = i_reg_wdata[eq_strobe_pkg::PORT_W-1:0];
        eq_strobe_pkg::ADDR_INDIRECT_CONTROL: // [R9]
          state_next.ind_control = i_reg_wdata &
            eq_strobe_pkg::IND_CONTROL_MASK; // [R19]
        eq_strobe_pkg::ADDR_INDIRECT_OFFSET: // [R9]
          state_next.ind_offset = i_reg_wdata;
        eq_strobe_pkg::ADDR_INDIRECT_DATA: // [R9]
        begin
          if (ind_strobe_sel)
            state_next.manual_strobe[ind_port] = i_reg_wdata; // [R14]
        end
        // Per-port registers land in the selected port's copy
        eq_strobe_pkg::ADDR_EQ_CONTROL:
          state_next.eq_control[port] = i_reg_wdata &
            eq_strobe_pkg::EQ_CONTROL_MASK; // [R5] [R8]
        eq_strobe_pkg::ADDR_EQ_BYPASS:
          state_next.eq_bypass[port] = i_reg_wdata; // [R1] [R8]
        eq_strobe_pkg::ADDR_EQ_ADAPTION_LIMITS:
          state_next.eq_limits[port] = i_reg_wdata; // [R2] [R4] [R8]
        default:
          state_next.port_sel = state_reg.port_sel; // Unmapped: ignored
      endcase
    end
    // Offset steps after every data access when auto-increment is set;
    // it wraps from 0xFF to 0x00. A write and a read of the data
    // register in one cycle step it only once.
    if (data_access && auto_inc)
      state_next.ind_offset = state_reg.ind_offset + 8'h01; // [R12]
    // Reads answer one cycle later; status bytes are sampled at the
    // taking edge, and a write in the same cycle is not yet visible
    if (i_reg_rd)
    begin
      state_next.rd_valid = 1'b1;
      case (i_reg_addr)
        eq_strobe_pkg::ADDR_PORT_SELECT:
          state_next.rdata = {7'h00, state_reg.port_sel};
        eq_strobe_pkg::ADDR_INDIRECT_CONTROL:
          state_next.rdata = state_reg.ind_control;
        eq_strobe_pkg::ADDR_INDIRECT_OFFSET:
          state_next.rdata = state_reg.ind_offset;
        eq_strobe_pkg::ADDR_INDIRECT_DATA:
          state_next.rdata = ind_strobe_sel ?
            state_reg.manual_strobe[ind_port] : 8'h00; // [R14]
        eq_strobe_pkg::ADDR_EQ_CONTROL:
          state_next.rdata = state_reg.eq_control[port]; // [R8]
        eq_strobe_pkg::ADDR_EQ_BYPASS:
          state_next.rdata = state_reg.eq_bypass[port]; // [R8]
        eq_strobe_pkg::ADDR_EQ_ADAPTION_LIMITS:
          state_next.rdata = state_reg.eq_limits[port]; // [R8]
        eq_strobe_pkg::ADDR_STROBE_CLOCK_DELAY_STATUS:
          state_next.rdata = {5'h00, i_applied_clock_delay[port]}; // [R6]
        eq_strobe_pkg::ADDR_STROBE_DATA_DELAY_STATUS:
          state_next.rdata = {5'h00, i_applied_data_delay[port]}; // [R7]
        default:
          state_next.rdata = 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // State register; the reset branch loads constants only, so both
  // ports come out of reset with the same settings
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg.port_sel <= eq_strobe_pkg::RST_PORT_SELECT[0];
      state_reg.ind_control <= eq_strobe_pkg::RST_INDIRECT;
      state_reg.ind_offset <= eq_strobe_pkg::RST_INDIRECT;
      state_reg.eq_control <= {eq_strobe_pkg::NUM_PORTS{
        eq_strobe_pkg::RST_EQ_CONTROL}}; // [R5]
      state_reg.eq_bypass <= {eq_strobe_pkg::NUM_PORTS{
        eq_strobe_pkg::RST_EQ_BYPASS}}; // [R1]
      state_reg.eq_limits <= {eq_strobe_pkg::NUM_PORTS{
        eq_strobe_pkg::RST_EQ_ADAPTION_LIMITS}}; // [R2] [R4]
      state_reg.manual_strobe <= {eq_strobe_pkg::NUM_PORTS{
        eq_strobe_pkg::RST_MANUAL_STROBE_DELAY}}; // [R15] [R16]
      state_reg.rdata <= 8'h00;
      state_reg.rd_valid <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  // Read answer
  assign o_reg_rdata = state_reg.rdata;
  assign o_reg_rd_valid = state_reg.rd_valid;

  // Per-port equaliser controls and strobe decoders
  genvar g;
  generate
    for (g = 0; g < eq_strobe_pkg::NUM_PORTS; g++)
    begin : g_port
      // Per-port link from the strobe byte to its decoder
      strobe_setting_if link ();

      // Each decoder sees only its own port's strobe byte
      assign link.setting = state_reg.manual_strobe[g];

      // Byte to buffer counts and sample offset
      strobe_delay_decode u_decode
      (
        .link(link.decoder)
      );

      // Bypass selects the manual stage values
      assign o_eq_adapt_enable[g] =
        ~state_reg.eq_bypass[g][eq_strobe_pkg::EQ_DISABLE_BIT]; // [R1]
      assign o_eq_manual_value[g] = {
        state_reg.eq_bypass[g][eq_strobe_pkg::EQ_STAGE1_HI:
          eq_strobe_pkg::EQ_STAGE1_LO],
        state_reg.eq_bypass[g][eq_strobe_pkg::EQ_STAGE2_HI:
          eq_strobe_pkg::EQ_STAGE2_LO]}; // [R1]
      assign o_eq_adapt_ceiling[g] =
        state_reg.eq_limits[g][eq_strobe_pkg::EQ_CEIL_HI:
          eq_strobe_pkg::EQ_CEIL_LO]; // [R2]
      // Start from the floor when enabled, else from zero
      assign o_eq_start_level[g] =
        state_reg.eq_control[g][eq_strobe_pkg::EQ_FLOOR_START_BIT] ?
        state_reg.eq_limits[g][eq_strobe_pkg::EQ_START_HI:
          eq_strobe_pkg::EQ_START_LO] : 4'h0; // [R4] [R5]
      // Decoded delays leave as the decoder gives them
      assign o_clock_delay_taps[g] = link.clock_taps; // [R15] [R16]
      assign o_data_delay_taps[g] = link.data_taps; // [R15] [R16]
      assign o_sample_offset[g] = link.sample_offset; // [R18]
    end
  endgenerate

endmodule // eq_strobe_control_regs
`default_nettype wire

/* File: hdl/eq_strobe_pkg.sv */
// Constants and types for the per-port equaliser and strobe register bank.
// Assumes a byte-wide register port fed by the serial configuration slave.
package eq_strobe_pkg;

  // Number of receive ports and register widths
  localparam int NUM_PORTS = 2;
  localparam int PORT_W = 1;
  localparam int TAP_W = 4;
  localparam int OFFSET_W = 5;

  // Main-space register offsets
  localparam logic [7:0] ADDR_PORT_SELECT = 8'h4C;
  localparam logic [7:0] ADDR_INDIRECT_CONTROL = 8'hB0;
  localparam logic [7:0] ADDR_INDIRECT_OFFSET = 8'hB1;
  localparam logic [7:0] ADDR_INDIRECT_DATA = 8'hB2;
  localparam logic [7:0] ADDR_EQ_CONTROL = 8'hD2;
  localparam logic [7:0] ADDR_EQ_BYPASS = 8'hD4;
  localparam logic [7:0] ADDR_EQ_ADAPTION_LIMITS = 8'hD5;
  localparam logic [7:0] ADDR_STROBE_CLOCK_DELAY_STATUS = 8'hD6;
  localparam logic [7:0] ADDR_STROBE_DATA_DELAY_STATUS = 8'hD7;

  // Indirect space: strobe block selects and register offset
  localparam logic [7:0] BLOCK_STROBE_PORT0 = 8'h04;
  localparam logic [7:0] BLOCK_STROBE_PORT1 = 8'h08;
  localparam logic [7:0] OFS_MANUAL_STROBE_DELAY = 8'h08;

  // Indirect control layout: block select in 7:2, auto-increment in 0
  localparam int IND_BLOCK_HI = 7;
  localparam int IND_BLOCK_LO = 2;
  localparam int IND_AUTO_INC_BIT = 0;
  localparam logic [7:0] IND_CONTROL_MASK = 8'hFD;

  // Equaliser field positions
  localparam int EQ_FLOOR_START_BIT = 2;
  localparam int EQ_DISABLE_BIT = 0;
  localparam int EQ_CEIL_HI = 7;
  localparam int EQ_CEIL_LO = 4;
  localparam int EQ_START_HI = 3;
  localparam int EQ_START_LO = 0;
  localparam int EQ_STAGE1_HI = 7;
  localparam int EQ_STAGE1_LO = 5;
  localparam int EQ_STAGE2_HI = 3;
  localparam int EQ_STAGE2_LO = 1;
  localparam logic [7:0] EQ_CONTROL_MASK = 8'h04;

  // Manual strobe field positions
  localparam int DATA_COARSE_BIT = 7;
  localparam int DATA_FINE_HI = 6;
  localparam int DATA_FINE_LO = 4;
  localparam int CLOCK_COARSE_BIT = 3;
  localparam int CLOCK_FINE_HI = 2;
  localparam int CLOCK_FINE_LO = 0;
  localparam logic [TAP_W-1:0] COARSE_EXTRA_TAPS = 4'h6;

  // Reset values
  localparam logic [7:0] RST_PORT_SELECT = 8'h00;
  localparam logic [7:0] RST_INDIRECT = 8'h00;
  localparam logic [7:0] RST_EQ_CONTROL = 8'h04;
  localparam logic [7:0] RST_EQ_BYPASS = 8'h60;
  localparam logic [7:0] RST_EQ_ADAPTION_LIMITS = 8'hF2;
  localparam logic [7:0] RST_MANUAL_STROBE_DELAY = 8'h00;

  // Whole register state of the bank
  typedef struct packed {
    logic [PORT_W-1:0] port_sel;
    logic [7:0] ind_control;
    logic [7:0] ind_offset;
    logic [NUM_PORTS-1:0][7:0] eq_control;
    logic [NUM_PORTS-1:0][7:0] eq_bypass;
    logic [NUM_PORTS-1:0][7:0] eq_limits;
    logic [NUM_PORTS-1:0][7:0] manual_strobe;
    logic [7:0] rdata;
    logic rd_valid;
  } bank_state_type;

endpackage

/* File: hdl/strobe_setting_if.sv */
// Carries one port's manual strobe byte and its decoded delays.
// Assumes both ends sit in the register clock domain.
`timescale 1ns/1ps
`default_nettype none
interface strobe_setting_if;
  logic [7:0] setting;
  logic [eq_strobe_pkg::TAP_W-1:0] clock_taps;
  logic [eq_strobe_pkg::TAP_W-1:0] data_taps;
  logic signed [eq_strobe_pkg::OFFSET_W-1:0] sample_offset;

  // Register bank side
  modport bank (output setting, input clock_taps, data_taps, sample_offset);
  // Decoder side
  modport decoder (input setting, output clock_taps, data_taps,
    sample_offset);
endinterface
`default_nettype wire

/* File: hdl/strobe_delay_decode.sv */
// Turns a manual strobe byte into buffer-delay counts and sample offset.
// Assumes the setting is held in flip-flops by the register bank.
`timescale 1ns/1ps
`default_nettype none
module strobe_delay_decode
(
  // Strobe setting link
  strobe_setting_if.decoder link
);

  logic [eq_strobe_pkg::TAP_W-1:0] clk_coarse;
  logic [eq_strobe_pkg::TAP_W-1:0] dat_coarse;

  // Coarse bit low adds six buffers, high adds none
  always_comb
  begin
    clk_coarse = link.setting[eq_strobe_pkg::CLOCK_COARSE_BIT] ?
      '0 : eq_strobe_pkg::COARSE_EXTRA_TAPS; // [R15]
    dat_coarse = link.setting[eq_strobe_pkg::DATA_COARSE_BIT] ?
      '0 : eq_strobe_pkg::COARSE_EXTRA_TAPS; // [R15]
  end

  // Fine field adds its own value in buffers
  assign link.clock_taps = clk_coarse + {1'b0,
    link.setting[eq_strobe_pkg::CLOCK_FINE_HI:eq_strobe_pkg::CLOCK_FINE_LO]};
    // [R16]
  assign link.data_taps = dat_coarse + {1'b0,
    link.setting[eq_strobe_pkg::DATA_FINE_HI:eq_strobe_pkg::DATA_FINE_LO]};
    // [R16]

  // Positive offset samples later, negative earlier
  assign link.sample_offset = $signed({1'b0, link.clock_taps}) -
    $signed({1'b0, link.data_taps}); // [R18]

endmodule // strobe_delay_decode
`default_nettype wire

/* File: test/eq_strobe_control_regs_properties.sv */
// Port checker for the equaliser and strobe register bank.
// Assumes one clock domain and byte strobes from the serial host.
`timescale 1ns/1ps
`default_nettype none
module eq_strobe_control_regs_properties
(
  // Clock, reset and register port
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rd_valid,
  // Per-port status and controls
  input wire logic [1:0][2:0] i_applied_clock_delay,
  input wire logic [1:0][2:0] i_applied_data_delay,
  input wire logic [1:0] o_eq_adapt_enable,
  input wire logic [1:0][3:0] o_eq_adapt_ceiling,
  input wire logic [1:0][3:0] o_eq_start_level,
  input wire logic [1:0][3:0] o_clock_delay_taps,
  input wire logic [1:0][3:0] o_data_delay_taps,
  input wire logic [1:0][4:0] o_sample_offset
);
  logic port_reg;
  // Strobe decodes
  wire logic wr_lim = i_reg_wr && i_reg_addr == 8'hD5;
  wire logic wr_byp = i_reg_wr && i_reg_addr == 8'hD4;
  wire logic wr_ctl = i_reg_wr && i_reg_addr == 8'hD2;
  // Tracks the selected port
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      port_reg <= 1'b0;
    else if (i_reg_wr && i_reg_addr == 8'h4C)
      port_reg <= i_reg_wdata[0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_RD_PULSE: assert property (o_reg_rd_valid == $past(i_reg_rd))
    else $error("read valid not one cycle after read");
  AST_BYPASS: assert property (wr_byp |=>
    o_eq_adapt_enable[port_reg] == !$past(i_reg_wdata[0]))
    else $error("adapt enable wrong after bypass write");
  AST_CEILING: assert property (wr_lim |=>
    o_eq_adapt_ceiling[port_reg] == $past(i_reg_wdata[7:4]))
    else $error("ceiling wrong after limit write");
  AST_START_OFF: assert property (wr_ctl && !i_reg_wdata[2] |=>
    o_eq_start_level[port_reg] == 4'h0)
    else $error("start level not zero without floor start");
  AST_RESET_VALS: assert property ($fell(i_rst) |->
    o_eq_adapt_ceiling == 8'hFF && o_eq_start_level == 8'h22 &&
    o_data_delay_taps == 8'h66 && o_sample_offset == 10'h000 &&
    o_clock_delay_taps == 8'h66 && o_eq_adapt_enable == 2'h3)
    else $error("control outputs wrong after reset");
  AST_CLK_STATUS: assert property (i_reg_rd && i_reg_addr == 8'hD6 |=>
    o_reg_rdata == {5'h00, $past(i_applied_clock_delay[port_reg])})
    else $error("clock delay status wrong");
  AST_DAT_STATUS: assert property (i_reg_rd && i_reg_addr == 8'hD7 |=>
    o_reg_rdata == {5'h00, $past(i_applied_data_delay[port_reg])})
    else $error("data delay status wrong");
  AST_OFFSET: assert property (o_sample_offset[1] ==
    5'({1'b0, o_clock_delay_taps[1]} - {1'b0, o_data_delay_taps[1]}))
    else $error("sample offset not clock minus data taps");
  // Main scenarios
  cover property (wr_lim);
  cover property (i_reg_rd && i_reg_addr == 8'hB2);
  cover property ($fell(i_rst));
endmodule // eq_strobe_control_regs_properties
bind eq_strobe_control_regs eq_strobe_control_regs_properties
  eq_strobe_control_regs_properties_i (.i_clk(i_clk), .i_rst(i_rst),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .o_reg_rd_valid(o_reg_rd_valid),
  .i_applied_clock_delay(i_applied_clock_delay),
  .i_applied_data_delay(i_applied_data_delay),
  .o_eq_adapt_enable(o_eq_adapt_enable),
  .o_eq_adapt_ceiling(o_eq_adapt_ceiling),
  .o_eq_start_level(o_eq_start_level),
  .o_clock_delay_taps(o_clock_delay_taps),
  .o_data_delay_taps(o_data_delay_taps), .o_sample_offset(o_sample_offset));
`default_nettype wire

/* File: test/host_model.sv */
// Configuration host issuing byte reads and writes to the bank.
// Assumes one-cycle strobes taken at the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
  // Clock
  input wire logic i_clk,
  // Register port towards the bank
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  input wire logic [7:0] i_rdata
);
  // Bus idles with strobes low
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Byte write; data inverted once released; returns once it landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    #1;
  endtask
  // Byte read; answer is settled just after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule // host_model
`default_nettype wire

/* File: test/tb_eq_strobe_control_regs.sv */
// Self-checking bench for the equaliser and strobe register bank.
// Assumes host_model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_eq_strobe_control_regs;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, rd_valid;
  logic [1:0][2:0] cdly = 6'h3D;
  logic [1:0][2:0] ddly = 6'h0A;
  logic [1:0] en;
  logic [1:0][5:0] man;
  logic [1:0][3:0] ceil, start, ctaps, dtaps;
  logic [1:0][4:0] ofs;
  logic [7:0] vals [5] = '{8'h00, 8'h8F, 8'hF8, 8'h88, 8'h37};
  int error_cnt = 0;
  int compares = 0;
  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;
  eq_strobe_control_regs eq_strobe_control_regs_i (.i_clk(i_clk),
    .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rd_valid(rd_valid),
    .i_applied_clock_delay(cdly), .i_applied_data_delay(ddly),
    .o_eq_adapt_enable(en), .o_eq_manual_value(man),
    .o_eq_adapt_ceiling(ceil), .o_eq_start_level(start),
    .o_clock_delay_taps(ctaps), .o_data_delay_taps(dtaps),
    .o_sample_offset(ofs));
  host_model host_model_i (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
  function automatic logic [3:0] taps(input logic c, input logic [2:0] f);
    return (c ? 4'h0 : 4'h6) + {1'b0, f};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_model_i.rd(a, d);
    chk({7'h00, rd_valid}, 8'h01);
    chk(d, exp);
  endtask
  task automatic sset(input logic p, input logic [7:0] v);
    host_model_i.wr(8'hB0, p ? 8'h08 : 8'h04);
    host_model_i.wr(8'hB1, 8'h08);
    host_model_i.wr(8'hB2, v);
  endtask
  task automatic end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    end_sim();
  end
  // Test sequence
  initial
  begin
    logic [3:0] ct, dt;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      host_model_i.wr(8'h4C, 8'(p));
      rchk(8'h4C, 8'(p));
      rchk(8'hD5, 8'hF2);
      rchk(8'hD2, 8'h04);
      rchk(8'hD4, 8'h60);
      host_model_i.wr(8'hD6, 8'hFF);
      rchk(8'hD6, {5'h00, cdly[p]});
      rchk(8'hD7, {5'h00, ddly[p]});
    end
    @(posedge i_clk);
    cdly <= 6'h16;
    ddly <= 6'h2C;
    rchk(8'hD6, 8'h02);
    rchk(8'hD7, 8'h05);
    host_model_i.wr(8'hD5, 8'h93);
    host_model_i.wr(8'hD4, 8'hA7);
    chk({4'h0, ceil[1]}, 8'h09);
    chk({4'h0, ceil[0]}, 8'h0F);
    chk({6'h00, en}, 8'h01);
    chk({2'h0, man[1]}, 8'h2B);
    chk({4'h0, start[1]}, 8'h03);
    host_model_i.wr(8'hD2, 8'h00);
    chk({4'h0, start[1]}, 8'h00);
    host_model_i.wr(8'h42, 8'h00);
    host_model_i.wr(8'h40, 8'h00);
    rchk(8'h42, 8'h00);
    foreach (vals[i])
    begin
      sset(i[0], vals[i]);
      ct = taps(vals[i][3], vals[i][2:0]);
      dt = taps(vals[i][7], vals[i][6:4]);
      chk({4'h0, ctaps[i[0]]}, {4'h0, ct});
      chk({4'h0, dtaps[i[0]]}, {4'h0, dt});
      chk({3'h0, ofs[i[0]]}, {3'h0, 5'({1'b0, ct} - {1'b0, dt})});
      rchk(8'hB2, vals[i]);
    end
    // Auto-increment across a dropped offset into the strobe register
    host_model_i.wr(8'hB0, 8'h0B);
    rchk(8'hB0, 8'h09);
    host_model_i.wr(8'hB1, 8'h07);
    host_model_i.wr(8'hB2, 8'hEE);
    host_model_i.wr(8'hB2, 8'h5A);
    rchk(8'hB1, 8'h09);
    chk({4'h0, ctaps[1]}, 8'h02);
    chk({4'h0, dtaps[1]}, 8'h0B);
    host_model_i.wr(8'hB1, 8'h08);
    rchk(8'hB2, 8'h5A);
    rchk(8'hB1, 8'h09);
    // Second reset in mid-run
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    rchk(8'h4C, 8'h00);
    host_model_i.wr(8'h4C, 8'h01);
    rchk(8'hD5, 8'hF2);
    rchk(8'hD4, 8'h60);
    rchk(8'hD2, 8'h04);
    chk({4'h0, ctaps[1]}, 8'h06);
    chk({4'h0, dtaps[1]}, 8'h06);
    end_sim();
  end
endmodule // tb_eq_strobe_control_regs
`default_nettype wire
